// ==== src/secp_defs.vh ====
/*
  Constants for the serial configuration memory port: register offsets,
  field positions, reset values, opcodes and serial timing counts.
  Assumes inclusion by the top design file of the port and by the bench files.
*/
`ifndef SECP_DEFS_VH
`define SECP_DEFS_VH

// Register byte offsets.
`define SECP_OFF_CTRL 12'h000
`define SECP_OFF_STAT 12'h004
`define SECP_OFF_DATA 12'h008
`define SECP_OFF_MASK 12'h00C
`define SECP_OFF_CFG0 12'h010
`define SECP_OFF_CFG1 12'h014
`define SECP_OFF_PROD 12'h018
`define SECP_OFF_FAIL 12'h01C
// Control register fields.
`define SECP_CTRL_GO 0
`define SECP_CTRL_OP_LO 1
`define SECP_CTRL_OP_HI 2
`define SECP_CTRL_ADR_LO 4
`define SECP_CTRL_ADR_HI 9
`define SECP_CTRL_BIG 12
`define SECP_CTRL_INSEL 13
// Operation codes (start bit excluded): read, write, erase, enable.
`define SECP_OP_READ 2'h0
`define SECP_OP_WRITE 2'h1
`define SECP_OP_ERASE 2'h2
`define SECP_OP_EWEN 2'h3
// Output port bit positions of select, shift clock and data in.
`define SECP_PORT_SEL 3'h5
`define SECP_PORT_CLK 3'h6
`define SECP_PORT_DIN 3'h7
// Reset values.
`define SECP_MASK_RST 8'h00
`define SECP_CTRL_RST 16'h0000
// Serial half period: 1000 ns at 4 ns clock.
`define SECP_HALF_NS 1000
`define SECP_CLK_NS 4
`define SECP_HALF_CYC ((`SECP_HALF_NS + `SECP_CLK_NS - 1) / `SECP_CLK_NS)
// Least select low time between operations: 1000 ns.
`define SECP_DESEL_NS 1000
`define SECP_DESEL_CYC ((`SECP_DESEL_NS + `SECP_CLK_NS - 1) / `SECP_CLK_NS)

`endif

// ==== src/secp_sync.v ====
/*
  Two-stage synchroniser for one level from outside the clock domain.
  Assumes a free-running CLOCK and a synchronous active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none

module secp_sync (
  // Clock and control
  input wire CLOCK,
  input wire RESET_N,
  input wire CE,
  // Level in and out
  input wire D,
  output wire Q
);
  reg meta_reg;
  reg sync_reg;

  // The first stage feeds only the second one.
  always @(posedge CLOCK) begin
    if (!RESET_N) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else if (CE) begin
      meta_reg <= D;
      sync_reg <= meta_reg;
    end
  end

  assign Q = sync_reg;
endmodule

`default_nettype wire

// ==== src/secp_ahb.v ====
/*
  AHB-Lite slave front end: captures the address phase and produces one
  write strobe or read strobe in the data phase. Always OKAY, zero wait while CE is high.
  Assumes single whole-word transfers and a register file behind it.
*/
`timescale 1ns/100ps
`default_nettype none

module secp_ahb (
  // Clock and control
  input wire CLOCK,
  input wire RESET_N,
  input wire CE,
  // AHB-Lite slave side
  input wire HSEL,
  input wire [11:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire HREADY,
  output wire HREADYOUT,
  output wire HRESP,
  // Register file side
  output wire wr_stb,
  output wire rd_stb,
  output wire [11:0] addr
);
  reg wr_reg;
  reg rd_reg;
  reg [11:0] addr_reg;

  // Address phase capture; NONSEQ or SEQ starts a transfer.
  always @(posedge CLOCK) begin
    if (!RESET_N) begin
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      addr_reg <= 12'h000;
    end else if (CE) begin
      wr_reg <= HSEL & HREADY & HTRANS[1] & HWRITE;
      rd_reg <= HSEL & HREADY & HTRANS[1] & ~HWRITE;
      if (HSEL & HREADY & HTRANS[1]) begin
        addr_reg <= HADDR;
      end
    end
  end

  // Data phase is stretched only while the clock enable holds hready low.
  assign HREADYOUT = CE;
  assign HRESP = 1'b0;
  assign wr_stb = wr_reg & CE;
  assign rd_stb = rd_reg & CE;
  assign addr = addr_reg;
endmodule

`default_nettype wire

// ==== src/secp_top.v ====
/*
  Serial configuration memory port. Software starts read, write, erase
  and erase/write-enable operations over AHB-Lite; the port drives an
  emulated eight-bit latched output port whose three bits form the
  memory's select, shift clock and serial data in, and samples the
  memory's data out from an input-port bit or a resistor-fed bus bit.
  Assumes a 250 MHz CLOCK and a memory of 16 or 64 words of 16 bits.
*/
// How it works
// - Select, clock, data from three port bits.
// - Data out via input port or bus.
// - Sixteen-bit words split into low, high accumulators.
// - Port writes go through readable shadow mask.
// - Read, write, erase, enable; serialise and assemble.
// - Word 0 holds cursor, screen, status bits.
// - Config word 1 holds line settings.
// - Words 2 to 8 hold production data.
// - Larger memory needs only longer address.
// - Word 9 holds two failure codes.
`timescale 1ns/100ps
`default_nettype none
`include "secp_defs.vh"

module secp_top (
  // Clock, reset and enable
  input wire CLOCK,
  input wire RESET_N,
  input wire CE,
  // AHB-Lite register bus
  input wire HSEL,
  input wire [11:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output wire HREADYOUT,
  output wire HRESP,
  output reg [31:0] HRDATA,
  // Latched output port and memory data return
  output wire [7:0] OUT_PORT,
  input wire IN_PORT_DOUT,
  input wire ROM_BUS_DOUT,
  // Decoded configuration
  output wire CURSOR_BLINK,
  output wire CURSOR_BLOCK,
  output wire CURSOR_INVERT,
  output wire SCREEN_INVERSE,
  output wire LOCAL_MODE,
  output wire STATUS_LINE,
  output wire [3:0] BAUD_SEL,
  output wire TWO_STOP,
  output wire EIGHT_DATA,
  output wire PARITY_ON,
  output wire PARITY_ODD,
  output wire [7:0] FAIL_CODE1,
  output wire [7:0] FAIL_CODE2
);
  localparam ST_IDLE = 3'h0;
  localparam ST_SEL = 3'h1;
  localparam ST_LOW = 3'h2;
  localparam ST_HIGH = 3'h3;
  localparam ST_DESEL = 3'h4;
  localparam integer HALF_N = `SECP_HALF_CYC;
  localparam integer DESEL_N = `SECP_DESEL_CYC;
  // Both counts fit the ten-bit timer; the cut is deliberate.
  localparam [9:0] HALF = HALF_N[9:0];
  localparam [9:0] DESEL = DESEL_N[9:0];

  wire wr_stb;
  wire rd_stb;
  wire [11:0] addr;
  wire in_port_sync;
  wire rom_bus_sync;
  reg [2:0] state_reg;
  reg [9:0] tmr_reg;
  reg [5:0] bit_reg;
  reg [5:0] nbits_reg;
  reg [25:0] shift_reg;
  reg [7:0] low_accumulator_reg;
  reg [7:0] high_accumulator_reg;
  reg [7:0] mask_reg;
  reg [15:0] ctrl_reg;
  reg busy_reg;
  reg done_reg;
  reg [15:0] cfg0_reg;
  reg [15:0] cfg1_reg;
  reg [15:0] fail_reg;
  reg [15:0] prod_reg;
  wire serial_data_out;
  wire [1:0] op_code;
  wire [5:0] word_addr;
  wire big_mem;

  // Returns a mask with one port bit forced to a level.
  function [7:0] set_bit;
    input [7:0] m;
    input [2:0] pos;
    input val;
    begin
      set_bit = m;
      set_bit[pos] = val;
    end
  endfunction

  secp_ahb u_ahb (
    .CLOCK(CLOCK),
    .RESET_N(RESET_N),
    .CE(CE),
    .HSEL(HSEL),
    .HADDR(HADDR),
    .HTRANS(HTRANS),
    .HWRITE(HWRITE),
    .HREADY(HREADY),
    .HREADYOUT(HREADYOUT),
    .HRESP(HRESP),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .addr(addr)
  );

  // Both return paths come from pins, so both are synchronised.
  secp_sync u_sync_in (
    .CLOCK(CLOCK),
    .RESET_N(RESET_N),
    .CE(CE),
    .D(IN_PORT_DOUT),
    .Q(in_port_sync)
  );
  secp_sync u_sync_bus (
    .CLOCK(CLOCK),
    .RESET_N(RESET_N),
    .CE(CE),
    .D(ROM_BUS_DOUT),
    .Q(rom_bus_sync)
  );

  // Input-port path when fitted, else the resistor-fed bus bit.
  assign serial_data_out = ctrl_reg[`SECP_CTRL_INSEL] ? in_port_sync : rom_bus_sync;
  assign op_code = ctrl_reg[`SECP_CTRL_OP_HI:`SECP_CTRL_OP_LO];
  assign word_addr = ctrl_reg[`SECP_CTRL_ADR_HI:`SECP_CTRL_ADR_LO];
  assign big_mem = ctrl_reg[`SECP_CTRL_BIG];

  // The port shows the shadow mask only; no bit is driven past it.
  assign OUT_PORT = mask_reg;

  // Register writes, operation launch and the serial engine.
  always @(posedge CLOCK) begin
    if (!RESET_N) begin
      state_reg <= ST_IDLE;
      tmr_reg <= 10'h000;
      bit_reg <= 6'h00;
      nbits_reg <= 6'h00;
      shift_reg <= 26'h0000000;
      low_accumulator_reg <= 8'h00;
      high_accumulator_reg <= 8'h00;
      mask_reg <= `SECP_MASK_RST;
      ctrl_reg <= `SECP_CTRL_RST;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      cfg0_reg <= 16'h0000;
      cfg1_reg <= 16'h0000;
      fail_reg <= 16'h0000;
      prod_reg <= 16'h0000;
    end else if (CE) begin
      if (wr_stb && !busy_reg) begin
        if (addr == `SECP_OFF_CTRL) begin
          ctrl_reg <= HWDATA[15:0];
          if (HWDATA[`SECP_CTRL_GO]) begin
            busy_reg <= 1'b1;
            state_reg <= ST_SEL;
            tmr_reg <= HALF;
          end
        end else if (addr == `SECP_OFF_DATA) begin
          low_accumulator_reg <= HWDATA[7:0];
          high_accumulator_reg <= HWDATA[15:8];
        end else if (addr == `SECP_OFF_MASK) begin
          // Serial bits stay under engine control; others are free.
          mask_reg <= {mask_reg[7:5], HWDATA[4:0]};
        end
      end
      if (wr_stb && !busy_reg && addr == `SECP_OFF_CTRL && HWDATA[`SECP_CTRL_GO]) begin
        done_reg <= 1'b0;
      end
      case (state_reg)
        ST_IDLE: begin
          // Nothing here: a timer load would override the launch load above.
        end
        ST_SEL: begin
          if (tmr_reg == 10'h001) begin
            // Frame: start bit, opcode, address, then data (write), dummy+data (read) or nothing (erase, enable).
            mask_reg <= set_bit(mask_reg, `SECP_PORT_SEL, 1'b1);
            if (big_mem) begin
              shift_reg <= {1'b1, op_code, word_addr, high_accumulator_reg,
                low_accumulator_reg, 1'b0};
              nbits_reg <= (op_code == `SECP_OP_WRITE) ? 6'h19 :
                ((op_code == `SECP_OP_READ) ? 6'h1A : 6'h09);
            end else begin
              shift_reg <= {1'b1, op_code, word_addr[3:0], high_accumulator_reg,
                low_accumulator_reg, 3'h0};
              nbits_reg <= (op_code == `SECP_OP_WRITE) ? 6'h17 :
                ((op_code == `SECP_OP_READ) ? 6'h18 : 6'h07);
            end
            bit_reg <= 6'h00;
            tmr_reg <= HALF;
            state_reg <= ST_LOW;
          end else begin
            tmr_reg <= tmr_reg - 10'h001;
          end
        end
        ST_LOW: begin
          // Data is set while the clock is low, sampled on its rise.
          mask_reg <= set_bit(set_bit(mask_reg, `SECP_PORT_CLK, 1'b0),
            `SECP_PORT_DIN, shift_reg[25]);
          if (tmr_reg == 10'h001) begin
            mask_reg <= set_bit(set_bit(mask_reg, `SECP_PORT_CLK, 1'b1),
              `SECP_PORT_DIN, shift_reg[25]);
            tmr_reg <= HALF;
            state_reg <= ST_HIGH;
          end else begin
            tmr_reg <= tmr_reg - 10'h001;
          end
        end
        ST_HIGH: begin
          if (tmr_reg == 10'h001) begin
            // Read bits arrive one slot later than written ones; the
            // leading zero dummy falls into the bit dropped at shift 9/7.
            shift_reg <= {shift_reg[24:0], serial_data_out};
            bit_reg <= bit_reg + 6'h01;
            tmr_reg <= HALF;
            if (bit_reg + 6'h01 == nbits_reg) begin
              state_reg <= ST_DESEL;
              tmr_reg <= DESEL;
              mask_reg <= set_bit(set_bit(mask_reg, `SECP_PORT_CLK, 1'b0),
                `SECP_PORT_SEL, 1'b0);
            end else begin
              // Drop the clock with the next bit now, so both halves last HALF.
              mask_reg <= set_bit(set_bit(mask_reg, `SECP_PORT_CLK, 1'b0),
                `SECP_PORT_DIN, shift_reg[24]);
              state_reg <= ST_LOW;
            end
          end else begin
            tmr_reg <= tmr_reg - 10'h001;
          end
        end
        ST_DESEL: begin
          if (tmr_reg == 10'h001) begin
            state_reg <= ST_IDLE;
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
            if (op_code == `SECP_OP_READ) begin
              low_accumulator_reg <= shift_reg[7:0];
              high_accumulator_reg <= shift_reg[15:8];
              // Mirror decoded words for the configuration outputs.
              if (word_addr == 6'h00) begin
                cfg0_reg <= shift_reg[15:0];
              end else if (word_addr == 6'h01) begin
                cfg1_reg <= shift_reg[15:0];
              end else if (word_addr == 6'h09) begin
                fail_reg <= shift_reg[15:0];
              end else if (word_addr >= 6'h02 && word_addr <= 6'h08) begin
                prod_reg <= shift_reg[15:0];
              end
            end
          end else begin
            tmr_reg <= tmr_reg - 10'h001;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Read data mux, registered in the data phase; unmapped reads zero.
  always @(posedge CLOCK) begin
    if (!RESET_N) begin
      HRDATA <= 32'h00000000;
    end else if (CE) begin
      if (HSEL && HREADY && HTRANS[1] && !HWRITE) begin
        if (HADDR == `SECP_OFF_CTRL) begin
          HRDATA <= {16'h0000, ctrl_reg};
        end else if (HADDR == `SECP_OFF_STAT) begin
          HRDATA <= {29'h00000000, serial_data_out, done_reg, busy_reg};
        end else if (HADDR == `SECP_OFF_DATA) begin
          HRDATA <= {16'h0000, high_accumulator_reg, low_accumulator_reg};
        end else if (HADDR == `SECP_OFF_MASK) begin
          HRDATA <= {24'h000000, mask_reg};
        end else if (HADDR == `SECP_OFF_CFG0) begin
          HRDATA <= {16'h0000, cfg0_reg};
        end else if (HADDR == `SECP_OFF_CFG1) begin
          HRDATA <= {16'h0000, cfg1_reg};
        end else if (HADDR == `SECP_OFF_PROD) begin
          HRDATA <= {16'h0000, prod_reg};
        end else if (HADDR == `SECP_OFF_FAIL) begin
          HRDATA <= {16'h0000, fail_reg};
        end else begin
          HRDATA <= 32'h00000000;
        end
      end
    end
  end

  // Configuration word 0 fields; bits 6 to 15 are spare.
  assign CURSOR_BLINK = cfg0_reg[0];
  assign CURSOR_BLOCK = cfg0_reg[1];
  assign CURSOR_INVERT = cfg0_reg[2];
  assign SCREEN_INVERSE = cfg0_reg[3];
  assign LOCAL_MODE = cfg0_reg[4];
  assign STATUS_LINE = cfg0_reg[5];
  // Configuration word 1 fields; bits 8 to 15 are spare.
  assign BAUD_SEL = cfg1_reg[3:0];
  assign TWO_STOP = cfg1_reg[4];
  assign EIGHT_DATA = cfg1_reg[5];
  assign PARITY_ON = cfg1_reg[6];
  assign PARITY_ODD = cfg1_reg[7];
  // Failure codes in the low and high bytes of word 9.
  assign FAIL_CODE1 = fail_reg[7:0];
  assign FAIL_CODE2 = fail_reg[15:8];
endmodule

`default_nettype wire

// ==== testbench/secp_asserts.sv ====
/* Checker for the serial memory port: frame shape on the port bits.
   Assumes it is bound to secp_top and that one clock serves all. */
`timescale 1ns/100ps
`default_nettype none
`include "secp_defs.vh"
module secp_asserts (
  // Clock and bus
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic HSEL,
  input wire logic [11:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  // Port side
  input wire logic [7:0] OUT_PORT,
  input wire logic [7:0] FAIL_CODE1
);
  wire sel = OUT_PORT[`SECP_PORT_SEL];
  wire clk = OUT_PORT[`SECP_PORT_CLK];
  logic [15:0] run_reg, gap_reg;
  logic [5:0] pls_reg;
  logic last_reg, mwr_reg;
  // Run lengths and pulse counts; the gap saturates so long idles never wrap.
  always @(posedge CLOCK) begin
    if (!RESET_N) begin
      run_reg <= 16'h0000;
      gap_reg <= 16'h0000;
      pls_reg <= 6'h00;
      last_reg <= 1'b0;
      mwr_reg <= 1'b0;
    end else begin
      last_reg <= clk;
      run_reg <= (clk != last_reg) ? 16'h0000 : run_reg + 16'h0001;
      gap_reg <= sel ? 16'h0000 : (&gap_reg ? gap_reg : gap_reg + 16'h0001);
      pls_reg <= !sel ? 6'h00 : pls_reg + {5'h00, clk & !last_reg};
      mwr_reg <= HSEL & HREADY & HTRANS[1] & HWRITE & (HADDR == `SECP_OFF_MASK);
    end
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  sequence s_sel_up;
    $rose(sel) ##0 !clk;
  endsequence
  sequence s_clk_low;
    !clk [*8];
  endsequence
  a_clk_needs_sel: assert property (clk |-> sel)
    else $error("shift clock high without select");
  a_reset_quiet: assert property ($rose(RESET_N) |-> OUT_PORT == 8'h00 && FAIL_CODE1 == 8'h00)
    else $error("outputs not cleared by reset");
  a_sel_lead: assert property (s_sel_up |=> s_clk_low)
    else $error("clock moved too soon after select");
  a_clk_high_half: assert property ($fell(clk) |-> run_reg == `SECP_HALF_CYC - 1)
    else $error("shift clock high time wrong");
  a_din_stable: assert property (clk && $past(clk) |-> $stable(OUT_PORT[`SECP_PORT_DIN]))
    else $error("data in moved while clock high");
  a_desel_gap: assert property ($rose(sel) |-> gap_reg >= `SECP_DESEL_CYC)
    else $error("select low time too short");
  a_frame_len: assert property ($fell(sel) |-> pls_reg inside {6'h07, 6'h09, 6'h17, 6'h18, 6'h19, 6'h1A})
    else $error("clock pulse count of frame wrong");
  a_sel_ends_low: assert property ($fell(sel) |-> !clk)
    else $error("select dropped with clock high");
  a_free_bits: assert property ($changed(OUT_PORT[4:0]) |-> $past(mwr_reg) || $past(mwr_reg, 2))
    else $error("free port bits changed without mask write");
endmodule
bind secp_top secp_asserts secp_asserts_i (
  .CLOCK(CLOCK), .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HREADY(HREADY), .OUT_PORT(OUT_PORT), .FAIL_CODE1(FAIL_CODE1));
`default_nettype wire

// ==== testbench/secp_mem_model.sv ====
/* Serial memory of 16 or 64 words of 16 bits, driven by the port.
   Assumes select, shift clock and data in come from the port bits. */
`timescale 1ns/100ps
`default_nettype none
`include "secp_defs.vh"
module secp_mem_model (
  // Serial lines and size strap
  input wire logic sel,
  input wire logic sk,
  input wire logic din,
  input wire logic big,
  // Data out
  output logic dout
);
  logic [15:0] mem [0:63];
  logic [31:0] sr = 32'h0;
  logic [5:0] a = 6'h00;
  logic [1:0] o = 2'h0;
  logic en = 1'b0;
  logic rd = 1'b0;
  int n = 0;
  int k = 0;
  int al;
  initial dout = 1'b1;
  // Deselect aborts the frame; the released line shows the inverse value.
  always @(negedge sel) begin
    n = 0;
    rd = 1'b0;
    dout = ~dout;
  end
  // Input bits count from the start bit; erase and write need the enable.
  always @(posedge sk) begin
    al = big ? 6 : 4;
    if (sel && (n > 0 || din)) begin
      sr = {sr[30:0], din};
      n++;
      if (n == 3 + al) begin
        o = big ? sr[7:6] : sr[5:4];
        a = big ? sr[5:0] : {2'h0, sr[3:0]};
        // The wire carries the port's own operation codes.
        rd = (o == `SECP_OP_READ);
        k = 0;
        if (o == `SECP_OP_EWEN) en = big ? (sr[5:4] == 2'h3) : (sr[3:2] == 2'h3);
        if (o == `SECP_OP_ERASE && en) mem[a] = 16'hFFFF;
      end
      if (n == 19 + al && o == `SECP_OP_WRITE && en) mem[a] = sr[15:0];
    end
  end
  // Output moves half a period after the rise that asked for it.
  always @(negedge sk) begin
    if (sel && rd) begin
      dout = (k == 0) ? 1'b0 : (k < 17 ? mem[a][16 - k] : ~dout);
      k++;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/serial_eeprom_config_port_tb_top.sv ====
/* Self-checking bench for the serial configuration memory port.
   Assumes the memory model answers on the selected return path. */
`timescale 1ns/100ps
`default_nettype none
`include "secp_defs.vh"
module serial_eeprom_config_port_tb_top;
  logic CLOCK = 1'b0;
  logic RESET_N = 1'b0;
  logic HSEL = 1'b0;
  logic HWRITE = 1'b0;
  logic [11:0] HADDR = 12'h000;
  logic [1:0] HTRANS = 2'h0;
  logic [31:0] HWDATA = 32'h0;
  logic [31:0] q;
  logic insel = 1'b0;
  logic big = 1'b0;
  logic [15:0] exp_mem [0:63];
  logic [5:0] ra [0:4] = '{6'h00, 6'h01, 6'h09, 6'h03, 6'h21};
  int errors = 0;
  int n_checks = 0;
  wire HREADYOUT, HRESP, dout, CURSOR_BLINK, CURSOR_BLOCK, CURSOR_INVERT, SCREEN_INVERSE;
  wire LOCAL_MODE, STATUS_LINE, TWO_STOP, EIGHT_DATA, PARITY_ON, PARITY_ODD;
  wire [31:0] HRDATA;
  wire [7:0] OUT_PORT, FAIL_CODE1, FAIL_CODE2;
  wire [3:0] BAUD_SEL;
  wire HREADY = HREADYOUT;
  // The unused path carries the inverse so a wrong path choice shows.
  wire IN_PORT_DOUT = insel ? dout : ~dout;
  wire ROM_BUS_DOUT = insel ? ~dout : dout;
  wire [5:0] cfg0_w = {STATUS_LINE, LOCAL_MODE, SCREEN_INVERSE, CURSOR_INVERT, CURSOR_BLOCK,
    CURSOR_BLINK};
  wire [7:0] cfg1_w = {PARITY_ODD, PARITY_ON, EIGHT_DATA, TWO_STOP, BAUD_SEL};
  secp_top secp_top_i (.CLOCK(CLOCK), .RESET_N(RESET_N), .CE(1'b1), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
    .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA),
    .OUT_PORT(OUT_PORT), .IN_PORT_DOUT(IN_PORT_DOUT), .ROM_BUS_DOUT(ROM_BUS_DOUT),
    .CURSOR_BLINK(CURSOR_BLINK), .CURSOR_BLOCK(CURSOR_BLOCK), .CURSOR_INVERT(CURSOR_INVERT),
    .SCREEN_INVERSE(SCREEN_INVERSE), .LOCAL_MODE(LOCAL_MODE), .STATUS_LINE(STATUS_LINE),
    .BAUD_SEL(BAUD_SEL), .TWO_STOP(TWO_STOP), .EIGHT_DATA(EIGHT_DATA), .PARITY_ON(PARITY_ON),
    .PARITY_ODD(PARITY_ODD), .FAIL_CODE1(FAIL_CODE1), .FAIL_CODE2(FAIL_CODE2));
  secp_mem_model secp_mem_model_i (.sel(OUT_PORT[`SECP_PORT_SEL]),
    .sk(OUT_PORT[`SECP_PORT_CLK]), .din(OUT_PORT[`SECP_PORT_DIN]), .big(big), .dout(dout));
  // Free-running clock.
  initial forever #2 CLOCK = ~CLOCK;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Waits for a rising edge with ready high, under a bound.
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge CLOCK);
      k++;
    end while (HREADYOUT !== 1'b1 && k < 64);
    if (HREADYOUT !== 1'b1) begin
      errors++;
      tally_and_finish();
    end
  endtask
  // One single transfer; read data is taken at the data phase edge.
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= a;
    HWRITE <= w;
    wait_rdy();
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    wait_rdy();
    q = HRDATA;
  endtask
  // Starts an operation, tries a mask write while busy, polls until done.
  task automatic op(input logic [1:0] o, input logic [5:0] a, input logic b, input logic s);
    int k;
    insel <= s;
    big <= b;
    bus(1'b1, `SECP_OFF_CTRL, {18'h0, s, b, 2'h0, a, 1'b0, o, 1'b1});
    bus(1'b0, `SECP_OFF_STAT, 32'h0);
    chk("busy", q[1:0], 2'h1);
    bus(1'b1, `SECP_OFF_MASK, 32'h0);
    k = 0;
    do begin
      bus(1'b0, `SECP_OFF_STAT, 32'h0);
      k++;
    end while (q[1] !== 1'b1 && k < 16000);
    if (q[1] !== 1'b1) begin
      errors++;
      tally_and_finish();
    end
    chk("done", q[1:0], 2'h2);
    bus(1'b0, `SECP_OFF_MASK, 32'h0);
    chk("mask kept", q[4:0], 5'h1F);
  endtask
  initial begin
    void'($urandom(32'h5572));
    for (int i = 0; i < 64; i++) begin
      exp_mem[i] = 16'($urandom);
      secp_mem_model_i.mem[i] = exp_mem[i];
    end
    repeat (12) @(posedge CLOCK);
    RESET_N <= 1'b1;
    @(posedge CLOCK);
    bus(1'b0, `SECP_OFF_MASK, 32'h0);
    chk("mask reset", q[7:0], `SECP_MASK_RST);
    bus(1'b0, `SECP_OFF_CTRL, 32'h0);
    chk("ctrl reset", q[15:0], `SECP_CTRL_RST);
    chk("resp", HRESP, 1'b0);
    bus(1'b1, `SECP_OFF_MASK, 32'hFF);
    repeat (2) @(posedge CLOCK);
    chk("port", OUT_PORT, 8'h1F);
    op(`SECP_OP_EWEN, 6'h0C, 1'b0, 1'b0);
    op(`SECP_OP_ERASE, 6'h00, 1'b0, 1'b0);
    chk("erased", secp_mem_model_i.mem[0], 16'hFFFF);
    exp_mem[0] = 16'($urandom);
    bus(1'b1, `SECP_OFF_DATA, {16'h0, exp_mem[0]});
    op(`SECP_OP_WRITE, 6'h00, 1'b0, 1'b1);
    chk("stored", secp_mem_model_i.mem[0], exp_mem[0]);
    for (int i = 0; i < 5; i++) begin
      op(`SECP_OP_READ, ra[i], i == 4, i[0]);
      bus(1'b0, `SECP_OFF_DATA, 32'h0);
      chk("data", q[15:0], exp_mem[ra[i]]);
      case (ra[i])
        6'h00: chk("cfg0", cfg0_w, exp_mem[0][5:0]);
        6'h01: chk("cfg1", cfg1_w, exp_mem[1][7:0]);
        6'h09: chk("fail", {FAIL_CODE2, FAIL_CODE1}, exp_mem[9]);
        6'h03: begin
          bus(1'b0, `SECP_OFF_PROD, 32'h0);
          chk("prod", q[15:0], exp_mem[3]);
        end
        default: chk("big read", q[15:0], exp_mem[33]);
      endcase
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
